// ---- src/dpt_consts.svh ----
// constants for the drive parameter telegram handler
`ifndef DPT_CONSTS_SVH
`define DPT_CONSTS_SVH
`define DPT_CMD_NONE 4'h0
`define DPT_CMD_READ 4'h1
`define DPT_CMD_WR_W 4'h2
`define DPT_CMD_WR_D 4'h3
`define DPT_CMD_WRE_D 4'hd
`define DPT_CMD_WRE_W 4'he
`define DPT_CMD_TEXT 4'hf
`define DPT_RSP_NONE 4'h0
`define DPT_RSP_WORD 4'h1
`define DPT_RSP_DWORD 4'h2
`define DPT_RSP_FAIL 4'h7
`define DPT_RSP_TEXT 4'hf
`define DPT_TXT_READ 8'h04
`define DPT_TXT_WRITE 8'h05
`define DPT_FLT_NO_PARAM 16'h0000
`define DPT_FLT_NO_WRITE 16'h0001
`define DPT_FLT_NO_INDEX 16'h0003
`define DPT_FLT_TYPE 16'h0005
`define DPT_DT_I16 8'h03
`define DPT_DT_I32 8'h04
`define DPT_DT_U8 8'h05
`define DPT_DT_U16 8'h06
`define DPT_DT_U32 8'h07
`define DPT_DT_TEXT 8'h09
`define DPT_DT_BYTES 8'h0a
`define DPT_DT_TDIFF 8'h0d
`define DPT_DT_RSVD 8'h21
`define DPT_DT_BITS 8'h23
`define DPT_CI_X100 8'h02
`define DPT_CI_X10 8'h01
`define DPT_CI_X1 8'h00
`define DPT_CI_D10 8'hff
`define DPT_CI_D100K 8'hfb
`define DPT_CI_D10B 8'h4a
`define DPT_NPAR 16
`define DPT_PAR_AW 4
`define DPT_MB_ADDR_MIN 8'h01
`define DPT_MB_ADDR_MAX 8'hf7
`define DPT_MB_BCAST 8'h00
`define DPT_PROT_NATIVE 1'b0
`define DPT_PROT_MODBUS 1'b1
`define DPT_RD_DAT 32'h0000_0000
`define DPT_RD_TYPE 32'h0000_0004
`define DPT_RD_SCALE 32'h0000_0008
`define DPT_RD_STAT 32'h0000_000c
`define DPT_RD_CTRL 32'h0000_0010
`define DPT_RD_PROT 32'h0000_0014
`define DPT_RD_PSEL 32'h0000_0018
`define DPT_CMD_LEN 8'h0e
`define DPT_ZERO16 16'h0000
`define DPT_ZERO8 8'h00
`endif

// ---- src/dpt_pkg.sv ----
// types for the drive parameter telegram handler
package dpt_pkg;
  // parameter block of one telegram, 12 bytes
  typedef struct packed {
    logic [3:0] code;
    logic [11:0] pnum;
    logic [15:0] index_word;
    logic [31:0] param_value_field;
    logic [15:0] pw1;
    logic [15:0] pw2;
  } dpt_tel_t;
  typedef struct packed {
    logic bcast;
    logic [7:0] length_byte;
  } dpt_hdr_t;
  typedef enum logic [1:0] {
    DPT_IDLE = 2'b00,
    DPT_EXEC = 2'b01,
    DPT_SEND = 2'b11
  } dpt_state_t;
endpackage

// ---- src/dpt_decode.sv ----
// decoder of a received parameter block into an action and an answer code
`timescale 1ns/1ps
`include "dpt_consts.svh"
module dpt_decode
  import dpt_pkg::*;
(
  input wire dpt_tel_t tel,
  input wire [7:0] dtype,
  input wire known,
  input wire writable,
  output logic do_write,
  output logic do_nvm,
  output logic fail,
  output logic [15:0] fault,
  output logic [3:0] rsp_code
);
  wire [3:0] c = tel.code;
  wire [7:0] ihi = tel.index_word[15:8];
  wire is_wr = (c == `DPT_CMD_WR_W) || (c == `DPT_CMD_WR_D) ||
               (c == `DPT_CMD_WRE_D) || (c == `DPT_CMD_WRE_W);
  wire is_txt = (c == `DPT_CMD_TEXT);
  wire txt_rd = is_txt && (ihi == `DPT_TXT_READ);
  wire txt_wr = is_txt && (ihi == `DPT_TXT_WRITE);
  wire txt_bad = is_txt && !txt_rd && !txt_wr;
  wire txt_type = (dtype == `DPT_DT_TEXT);
  wire is_rd = (c == `DPT_CMD_READ);
  wire bad_cmd = !(is_wr || is_txt || is_rd || c == `DPT_CMD_NONE);
  wire e_nop = !known && c != `DPT_CMD_NONE;
  wire e_wr = (is_wr || txt_wr) && !writable;
  wire e_ty = is_txt && !txt_type && !txt_bad;
  // fault selection in priority order
  assign fault = e_nop ? `DPT_FLT_NO_PARAM : (txt_bad || bad_cmd) ? `DPT_FLT_NO_INDEX :
                 e_ty ? `DPT_FLT_TYPE : e_wr ? `DPT_FLT_NO_WRITE : `DPT_ZERO16;
  assign fail = e_nop || txt_bad || bad_cmd || e_ty || e_wr;
  assign do_write = !fail && (is_wr || txt_wr);
  assign do_nvm = do_write && (c == `DPT_CMD_WRE_W || c == `DPT_CMD_WRE_D);
  assign rsp_code = fail ? `DPT_RSP_FAIL : is_txt ? `DPT_RSP_TEXT :
                    (c == `DPT_CMD_NONE) ? `DPT_RSP_NONE :
                    (c == `DPT_CMD_WR_D || c == `DPT_CMD_WRE_D) ? `DPT_RSP_DWORD :
                    (dtype == `DPT_DT_U32 || dtype == `DPT_DT_I32) ? `DPT_RSP_DWORD :
                    `DPT_RSP_WORD;
endmodule

// ---- src/dpt_wb.sv ----
// classic wishbone slave decode with one-cycle ack
`timescale 1ns/1ps
`include "dpt_consts.svh"
module dpt_wb (
  input wire CLK,
  input wire RST_N,
  input wire cyc,
  input wire stb,
  output logic ack_r,
  output logic req
);
  // ack drops the cycle after it rises, so a held request is taken once
  assign req = cyc && stb && !ack_r;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end
endmodule

// ---- src/dpt_top.sv ----
// drive parameter telegram interpreter with wishbone register access
`timescale 1ns/1ps
`include "dpt_consts.svh"
// Behaviour
// - value field is two words, meaning by command
// - read returns current value in value field
// - write stores value field as new content
// - enumerated choices are written as option index
// - text read: command F, index high 4
// - text write: command F, index high 5
// - text length carried in length byte
// - text read only for data type 9
// - data type codes as fixed table
// - whole numbers scaled by conversion index
// - two process words in fixed order
// - command E writes working and nonvolatile memory
// - under modbus only answer, never initiate
// - no answer to broadcast queries
// - errors give error answer or silence
// - protocol select, modbus address 1 to 247
// - code in bits 15:12, number 11:0
// - failure answers code 7 plus fault
// - only index low byte selects array element
module dpt_top
  import dpt_pkg::*;
(
  input wire CLK,
  input wire RST_N,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [31:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  input wire [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire TEL_VALID,
  input wire [7:0] TEL_LENGTH,
  input wire TEL_BCAST,
  input wire TEL_RX_ERR,
  input wire [95:0] TEL_DATA,
  output logic RSP_VALID,
  output logic [95:0] RSP_DATA,
  output logic [7:0] RSP_LENGTH,
  output logic NVM_WRITE,
  output logic [11:0] NVM_PNUM,
  output logic [31:0] CTRL_REF,
  output logic PROTOCOL_SEL,
  output logic [7:0] MB_ADDR
);
  // parameter store; index low byte picks the element
  logic [31:0] par_val_r [0:`DPT_NPAR-1];
  logic [7:0] par_type_r [0:`DPT_NPAR-1];
  logic [7:0] par_scale_r [0:`DPT_NPAR-1];
  logic par_wr_r [0:`DPT_NPAR-1];
  logic [`DPT_PAR_AW-1:0] psel_r;
  logic [15:0] status_r;
  logic [15:0] outfreq_r;
  logic prot_r;
  logic [7:0] mbaddr_r;
  logic [1:0] errmode_r;
  logic [7:0] rx_cnt_r;
  dpt_state_t state_r;
  dpt_tel_t tel_r;
  dpt_hdr_t hdr_r;
  logic [31:0] dat_r;
  logic ack_w;
  logic req_w;
  dpt_wb u_wb (
    .CLK(CLK),
    .RST_N(RST_N),
    .cyc(WB_CYC_I),
    .stb(WB_STB_I),
    .ack_r(ack_w),
    .req(req_w)
  );
  // element address from parameter number and index low byte
  function automatic logic [`DPT_PAR_AW-1:0] dpt_slot(input logic [11:0] pn,
                                                       input logic [7:0] il);
    logic [`DPT_PAR_AW:0] sum;
    sum = {1'b0, pn[`DPT_PAR_AW-1:0]} + {1'b0, il[`DPT_PAR_AW-1:0]};
    // the carry is dropped on purpose: slots wrap around the store
    dpt_slot = sum[`DPT_PAR_AW-1:0];
  endfunction
  function automatic logic dpt_known(input logic [11:0] pn, input logic [7:0] il);
    dpt_known = (pn < 12'(`DPT_NPAR)) && (il < 8'(`DPT_NPAR));
  endfunction
  wire [`DPT_PAR_AW-1:0] slot = dpt_slot(tel_r.pnum, tel_r.index_word[7:0]);
  wire known = dpt_known(tel_r.pnum, tel_r.index_word[7:0]) &&
               (32'(slot) < `DPT_NPAR);
  logic do_write;
  logic do_nvm;
  logic fail;
  logic [15:0] fault;
  logic [3:0] rsp_code;
  dpt_decode u_dec (
    .tel(tel_r),
    .dtype(par_type_r[slot]),
    .known(known),
    .writable(par_wr_r[slot]),
    .do_write(do_write),
    .do_nvm(do_nvm),
    .fail(fail),
    .fault(fault),
    .rsp_code(rsp_code)
  );
  // bus decode
  wire wr = req_w && WB_WE_I && WB_SEL_I == 4'hf;
  wire a_dat = WB_ADR_I == `DPT_RD_DAT;
  wire a_type = WB_ADR_I == `DPT_RD_TYPE;
  wire a_scale = WB_ADR_I == `DPT_RD_SCALE;
  wire a_stat = WB_ADR_I == `DPT_RD_STAT;
  wire a_ctrl = WB_ADR_I == `DPT_RD_CTRL;
  wire a_prot = WB_ADR_I == `DPT_RD_PROT;
  wire a_psel = WB_ADR_I == `DPT_RD_PSEL;
  // bad modbus addresses are dropped so the slave never takes 0 or 248 up
  wire mb_ok = WB_DAT_I[15:8] >= `DPT_MB_ADDR_MIN && WB_DAT_I[15:8] <= `DPT_MB_ADDR_MAX;
  wire [31:0] rd_mux = a_dat ? par_val_r[psel_r] :
                       a_type ? {24'h0, par_type_r[psel_r]} :
                       a_scale ? {23'h0, par_wr_r[psel_r], par_scale_r[psel_r]} :
                       a_stat ? {outfreq_r, status_r} :
                       a_ctrl ? CTRL_REF :
                       a_prot ? {14'h0, errmode_r, mbaddr_r, 7'h0, prot_r} :
                       a_psel ? {28'h0, psel_r} : 32'h0;
  // an unmapped address reads zero, writes are ignored
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dat_r <= 32'h0;
    end else if (req_w) begin
      dat_r <= rd_mux;
    end
  end
  assign WB_DAT_O = dat_r;
  assign WB_ACK_O = ack_w;
  // configuration registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prot_r <= `DPT_PROT_NATIVE;
      mbaddr_r <= `DPT_MB_ADDR_MIN;
      errmode_r <= 2'h0;
      psel_r <= '0;
      status_r <= `DPT_ZERO16;
      outfreq_r <= `DPT_ZERO16;
    end else if (wr) begin
      if (a_prot) begin
        prot_r <= WB_DAT_I[0];
        errmode_r <= WB_DAT_I[17:16];
        if (mb_ok) mbaddr_r <= WB_DAT_I[15:8];
      end
      if (a_psel) psel_r <= WB_DAT_I[`DPT_PAR_AW-1:0];
      if (a_stat) begin
        status_r <= WB_DAT_I[15:0];
        outfreq_r <= WB_DAT_I[31:16];
      end
    end
  end
  // parameter store: software sets attributes, telegrams change values
  // a garbled telegram is never acted on, whatever its command says
  wire rx_bad = rx_cnt_r != `DPT_ZERO8;
  wire tel_wr = (state_r == DPT_EXEC) && do_write && !rx_bad;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < `DPT_NPAR; i++) begin
        par_val_r[i] <= 32'h0;
        par_type_r[i] <= `DPT_DT_U16;
        par_scale_r[i] <= `DPT_CI_X1;
        par_wr_r[i] <= 1'b1;
      end
    end else begin
      if (tel_wr) begin
        par_val_r[slot] <= tel_r.param_value_field;
      end else if (wr && a_dat) begin
        par_val_r[psel_r] <= WB_DAT_I;
      end
      if (wr && a_type) par_type_r[psel_r] <= WB_DAT_I[7:0];
      if (wr && a_scale) begin
        par_scale_r[psel_r] <= WB_DAT_I[7:0];
        par_wr_r[psel_r] <= WB_DAT_I[8];
      end
    end
  end
  // telegram engine: catch, execute, answer
  wire silent = hdr_r.bcast || (fail && errmode_r[0]);
  // a receive error answers as a failure unless software asked for silence
  wire [3:0] ans_code = rx_bad ? `DPT_RSP_FAIL : rsp_code;
  wire [31:0] rd_val = (fail || rx_bad) ? {`DPT_ZERO16, fault} :
                       par_val_r[slot];
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= DPT_IDLE;
      tel_r <= '0;
      hdr_r <= '0;
      rx_cnt_r <= `DPT_ZERO8;
      RSP_VALID <= 1'b0;
      RSP_DATA <= '0;
      RSP_LENGTH <= `DPT_ZERO8;
      NVM_WRITE <= 1'b0;
      NVM_PNUM <= 12'h0;
      CTRL_REF <= 32'h0;
    end else begin
      RSP_VALID <= 1'b0;
      NVM_WRITE <= 1'b0;
      case (state_r)
        DPT_IDLE: begin
          // the engine only reacts to incoming queries, it never starts one
          if (TEL_VALID) begin
            tel_r <= TEL_DATA;
            hdr_r <= '{bcast: TEL_BCAST, length_byte: TEL_LENGTH};
            rx_cnt_r <= {7'h0, TEL_RX_ERR};
            state_r <= DPT_EXEC;
          end
        end
        DPT_EXEC: begin
          if (!rx_bad) begin
            CTRL_REF <= {tel_r.pw2, tel_r.pw1};
          end
          NVM_WRITE <= do_nvm && !rx_bad;
          NVM_PNUM <= tel_r.pnum;
          state_r <= DPT_SEND;
        end
        DPT_SEND: begin
          RSP_VALID <= !silent && !(rx_bad && errmode_r[1]);
          RSP_DATA <= {ans_code, tel_r.pnum, tel_r.index_word, rd_val, status_r, outfreq_r};
          RSP_LENGTH <= (tel_r.code == `DPT_CMD_TEXT) ? hdr_r.length_byte :
                        `DPT_CMD_LEN;
          rx_cnt_r <= `DPT_ZERO8;
          state_r <= DPT_IDLE;
        end
        default: state_r <= DPT_IDLE;
      endcase
    end
  end
  assign PROTOCOL_SEL = prot_r;
  assign MB_ADDR = mbaddr_r;
endmodule

// ---- verif/dpt_checker.sv ----
// assertions on the telegram ports of the parameter handler
`timescale 1ns/1ps
module dpt_checker (
  input wire CLK,
  input wire RST_N,
  input wire TEL_VALID,
  input wire [7:0] TEL_LENGTH,
  input wire TEL_BCAST,
  input wire TEL_RX_ERR,
  input wire [95:0] TEL_DATA,
  input wire RSP_VALID,
  input wire [95:0] RSP_DATA,
  input wire [7:0] RSP_LENGTH,
  input wire NVM_WRITE,
  input wire [11:0] NVM_PNUM,
  input wire [31:0] CTRL_REF,
  input wire [7:0] MB_ADDR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // clean individual query, and one whose slot surely exists
  wire ans = TEL_VALID && !TEL_BCAST && !TEL_RX_ERR;
  wire known = TEL_DATA[91:84] == 8'h00 && TEL_DATA[71:68] == 4'h0;
  property p_bcast; TEL_VALID && TEL_BCAST |-> ##3 !RSP_VALID; endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast answered");
  property p_answer; RSP_VALID |-> $past(TEL_VALID, 3); endproperty
  a_answer: assert property (p_answer) else $error("unasked response");
  property p_echo; ans ##3 RSP_VALID |->
    RSP_DATA[91:80] == $past(TEL_DATA[91:80], 3); endproperty
  a_echo: assert property (p_echo) else $error("number not echoed");
  property p_proc; ans && known && TEL_DATA[95:92] == 4'h1 |->
    ##2 CTRL_REF == {$past(TEL_DATA[15:0], 2), $past(TEL_DATA[31:16], 2)}; endproperty
  a_proc: assert property (p_proc) else $error("process words");
  property p_nvm; NVM_WRITE |-> $past(TEL_DATA[95:92], 2) inside {4'hd, 4'he} &&
    NVM_PNUM == $past(TEL_DATA[91:80], 2); endproperty
  a_nvm: assert property (p_nvm) else $error("stray commit");
  property p_txt; ans && known && TEL_DATA[95:92] == 4'hf && !(TEL_DATA[79:72] inside
    {8'h04, 8'h05}) ##3 RSP_VALID |->
    RSP_DATA[95:92] == 4'h7 && RSP_DATA[47:32] == 16'h0003; endproperty
  a_txt: assert property (p_txt) else $error("bad text index");
  property p_len; ans ##3 RSP_VALID |-> RSP_LENGTH ==
    ($past(TEL_DATA[95:92], 3) == 4'hf ? $past(TEL_LENGTH, 3) : 8'h0e); endproperty
  a_len: assert property (p_len) else $error("length byte");
  property p_addr; MB_ADDR >= 8'h01 && MB_ADDR <= 8'hf7; endproperty
  a_addr: assert property (p_addr) else $error("address range");
endmodule
bind dpt_top dpt_checker i_dpt_checker (.CLK, .RST_N, .TEL_VALID, .TEL_LENGTH, .TEL_BCAST,
  .TEL_RX_ERR, .TEL_DATA, .RSP_VALID, .RSP_DATA, .RSP_LENGTH, .NVM_WRITE, .NVM_PNUM,
  .CTRL_REF, .MB_ADDR);

// ---- verif/dpt_master_model.sv ----
// fieldbus master model handing checked telegrams to the handler
`timescale 1ns/1ps
`include "dpt_consts.svh"
module dpt_master_model
  import dpt_pkg::*;
(
  input wire clk,
  output logic tel_valid = 1'b0,
  output logic [7:0] tel_len = 8'h00,
  output logic tel_bc = 1'b0,
  output logic tel_err = 1'b0,
  output logic [95:0] tel_data = '0
);
  dpt_tel_t cur;
  // one query per call; lines flip afterwards so stale data is never mistaken
  task automatic send(input dpt_tel_t t, input logic [7:0] l, input logic b, input logic e);
    cur = t;
    if (t.code == `DPT_CMD_READ)
      cur.param_value_field = '0;
    @(posedge clk);
    tel_valid <= 1'b1;
    tel_data <= cur;
    tel_len <= l;
    tel_bc <= b;
    tel_err <= e;
    @(posedge clk);
    tel_valid <= 1'b0;
    tel_data <= ~cur;
  endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the parameter telegram handler
`timescale 1ns/1ps
`include "dpt_consts.svh"
module testbench;
  import dpt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [3:0] sel = 4'hf;
  logic [31:0] rdat, q, v, pw, st;
  logic ack, tv, tb, te, rv, got, psel, nvm, nw;
  logic [11:0] npo, npn, pn;
  logic [7:0] tl, rl, rlen, mba;
  logic [95:0] td, rd, rsp;
  logic [3:0] s, c;
  logic [15:0] ix;
  int num_errors = 0;
  int total_checks = 0;
  logic [3:0] wcmd [4] = '{4'h2, 4'h3, 4'hd, 4'he};
  logic [7:0] dts [10] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0d, 8'h21, 8'h23};
  logic [7:0] cis [6] = '{8'h02, 8'h01, 8'h00, 8'hff, 8'hfb, 8'h4a};
  dpt_top i_dpt_top (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .TEL_VALID(tv), .TEL_LENGTH(tl), .TEL_BCAST(tb), .TEL_RX_ERR(te), .TEL_DATA(td),
    .RSP_VALID(rv), .RSP_DATA(rd), .RSP_LENGTH(rl), .NVM_WRITE(nvm), .NVM_PNUM(npo), .CTRL_REF(),
    .PROTOCOL_SEL(psel), .MB_ADDR(mba));
  dpt_master_model i_dpt_master_model (.clk(clk), .tel_valid(tv), .tel_len(tl), .tel_bc(tb),
    .tel_err(te), .tel_data(td));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] m);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= m;
    // no wait is assumed; only the watchdog ends a hung cycle
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] m,
    input logic [31:0] e);
    wb(1'b0, a, '0, 4'hf);
    check(n, q & m, e);
  endtask
  // answer is due three edges after the take edge; five edges covers it and the spacing
  task automatic tel(input logic [3:0] k, input logic [11:0] p, input logic [15:0] x,
    input logic [31:0] d, input logic [7:0] l, input logic b, input logic e);
    pw = $urandom();
    got = 1'b0;
    nw = 1'b0;
    npn = 12'h0;
    i_dpt_master_model.send({k, p, x, d, pw}, l, b, e);
    repeat (5) begin
      @(posedge clk);
      if (rv === 1'b1) begin
        got = 1'b1;
        rsp = rd;
        rlen = rl;
      end
      if (nvm === 1'b1) begin
        nw = 1'b1;
        npn = npo;
      end
    end
  endtask
  function automatic logic [3:0] ok_code(input logic [3:0] k);
    return (k == `DPT_CMD_WR_D || k == `DPT_CMD_WRE_D) ? `DPT_RSP_DWORD : `DPT_RSP_WORD;
  endfunction
  initial begin
    void'($urandom(69));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc("type", `DPT_RD_TYPE, 32'hff, 32'h6);
    rdc("wrbl", `DPT_RD_SCALE, 32'h100, 32'h100);
    rdc("prot", `DPT_RD_PROT, '1, 32'h100);
    rdc("gap", 32'h40, '1, 32'h0);
    st = $urandom();
    wb(1'b1, `DPT_RD_STAT, st, 4'hf);
    for (int k = 0; k < 8; k++) begin
      s = 4'($urandom());
      ix = {8'($urandom()), 4'h0, 4'($urandom())};
      c = wcmd[k % 4];
      v = (c == 4'h2 || c == 4'he) ? {16'h0, 16'($urandom())} : $urandom();
      pn = {8'h00, 4'(s - ix[3:0])};
      tel(c, pn, ix, v, 8'h0e, 1'b0, 1'b0);
      check("wcode", {got, rsp[95:92]}, {1'b1, ok_code(c)});
      check("nvm", {nw, npn}, (c == 4'hd || c == 4'he) ? {1'b1, pn} : 13'h0);
      tel(`DPT_CMD_READ, pn, ix, $urandom(), 8'h0e, 1'b0, 1'b0);
      check("rval", {rsp[95:92], rsp[63:32]}, {4'h1, v});
      check("stat", rsp[31:0], {st[15:0], st[31:16]});
      rdc("ctrl", `DPT_RD_CTRL, '1, {pw[15:0], pw[31:16]});
      wb(1'b1, `DPT_RD_PSEL, {28'h0, s}, 4'hf);
      rdc("mem", `DPT_RD_DAT, '1, v);
    end
    tel(`DPT_CMD_READ, 12'h010, 16'h0, 32'h0, 8'h0e, 1'b0, 1'b0);
    check("nopar", {rsp[95:92], rsp[47:32]}, {4'h7, `DPT_FLT_NO_PARAM});
    wb(1'b1, `DPT_RD_PSEL, 32'h0, 4'hf);
    tel(4'hf, 12'h0, 16'h0400, 32'h0, 8'h12, 1'b0, 1'b0);
    check("txt6", {rsp[95:92], rsp[47:32]}, {4'h7, `DPT_FLT_TYPE});
    wb(1'b1, `DPT_RD_TYPE, 32'h9, 4'hf);
    tel(4'hf, 12'h0, 16'h0500, v, 8'h13, 1'b0, 1'b0);
    check("twr", {rsp[95:92], rlen}, {4'hf, 8'h13});
    tel(4'hf, 12'h0, 16'h0400, 32'h0, 8'h12, 1'b0, 1'b0);
    check("trd", {rsp[95:92], rsp[63:32]}, {4'hf, v});
    tel(4'hf, 12'h0, 16'h0700, 32'h0, 8'h12, 1'b0, 1'b0);
    check("tbad", {rsp[95:92], rsp[47:32]}, {4'h7, `DPT_FLT_NO_INDEX});
    tel(4'h4, 12'h0, 16'h0, 32'h0, 8'h0e, 1'b0, 1'b0);
    check("bcmd", {rsp[95:92], rsp[47:32]}, {4'h7, `DPT_FLT_NO_INDEX});
    tel(`DPT_CMD_NONE, 12'h0, 16'h0, 32'h0, 8'h0e, 1'b0, 1'b0);
    check("none", {got, rsp[95:92]}, {1'b1, `DPT_RSP_NONE});
    wb(1'b1, `DPT_RD_SCALE, 32'h0, 4'hf);
    tel(`DPT_CMD_WR_W, 12'h0, 16'h0, v, 8'h0e, 1'b0, 1'b0);
    check("nowr", {rsp[95:92], rsp[47:32]}, {4'h7, `DPT_FLT_NO_WRITE});
    tel(`DPT_CMD_READ, 12'h0, 16'h0, 32'h0, 8'h0e, 1'b1, 1'b0);
    check("bcast", got, 1'b0);
    tel(`DPT_CMD_READ, 12'h0, 16'h0, 32'h0, 8'h0e, 1'b0, 1'b1);
    check("rxerr", {got, rsp[95:92]}, {1'b1, `DPT_RSP_FAIL});
    wb(1'b1, `DPT_RD_PROT, 32'h0003_0501, 4'hf);
    tel(`DPT_CMD_READ, 12'h0, 16'h0, 32'h0, 8'h0e, 1'b0, 1'b1);
    check("rxq", {got, psel, mba}, {1'b0, 1'b1, 8'h05});
    tel(`DPT_CMD_READ, 12'h020, 16'h0, 32'h0, 8'h0e, 1'b0, 1'b0);
    check("failq", got, 1'b0);
    wb(1'b1, `DPT_RD_PROT, 32'h0003_f801, 4'hf);
    check("mbad", mba, 8'h05);
    wb(1'b1, `DPT_RD_PSEL, 32'h5, 4'h7);
    rdc("psel", `DPT_RD_PSEL, 32'hf, 32'h0);
    for (int k = 0; k < 10; k++) begin
      wb(1'b1, `DPT_RD_TYPE, {24'h0, dts[k]}, 4'hf);
      rdc("dtype", `DPT_RD_TYPE, 32'hff, {24'h0, dts[k]});
      wb(1'b1, `DPT_RD_SCALE, {23'h0, 1'b1, cis[k % 6]}, 4'hf);
      rdc("conv", `DPT_RD_SCALE, 32'h1ff, {23'h0, 1'b1, cis[k % 6]});
    end
    complete_run();
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule
